// File: fsbt_peer.sv
// Remote serial peer: frames bytes onto the line and decodes the device's bytes
module fsbt_peer #(
   parameter int BT = 24
) (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 100ps;
   initial rxd = 1'b1;
   // Start, eight data bits low first, stop; line rests high after
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge clk); // Frame starts just after an edge
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BT) @(posedge clk);
      end
   endtask : send
   // Sample mid-bit on the falling edge so the register output has settled
   task automatic get(output logic [7:0] b);
      int k;
      b = 'x;
      k = 0;
      while (txd !== 1'b0 && k < 20000) begin
         @(negedge clk);
         k++;
      end
      repeat (BT / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BT) @(negedge clk);
         b[i] = (k < 20000) ? txd : 1'bx;
      end
      repeat (BT) @(negedge clk);
   endtask : get
endmodule : fsbt_peer

// File: fsbt_pkg.sv
// Shared constants, types and register map of the fast serial block transfer port
package fsbt_pkg;

   // ---------------------------------------------------------------
   // Clocking
   // ---------------------------------------------------------------
   localparam int REF_CLK_HZ = 48_000_000; // Nominal bit-rate reference
   localparam int CLK_HZ = 40_000_000;     // Block clock, one divider step per rising edge

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int APB_AW = 18;
   localparam logic [15:0] IDX_CTRL = 16'hC070;
   localparam logic [15:0] IDX_DIV = 16'hC072;
   localparam logic [15:0] IDX_GAP = 16'hC074;
   localparam logic [15:0] IDX_DATA = 16'hC076;
   localparam logic [15:0] IDX_RX_PTR = 16'hC078;
   localparam logic [15:0] IDX_RX_LEN = 16'hC07A;
   localparam logic [15:0] IDX_TX_PTR = 16'hC07C;
   localparam logic [15:0] IDX_TX_LEN = 16'hC07E;

   // ---------------------------------------------------------------
   // Field widths and positions
   // ---------------------------------------------------------------
   localparam int DIV_W = 13;
   localparam int GAP_W = 8;
   localparam int LEN_W = 10;
   localparam int PTR_W = 16;
   localparam int BYTE_W = 8;
   localparam int CTL_RX_BUSY = 9;
   localparam int CTL_TX_BUSY = 8;
   localparam int CTL_TX_DONE = 7;
   localparam int CTL_RX_DONE = 6;
   localparam int CTL_ONE_STOP = 5;
   localparam int CTL_TX_FREE = 4;
   localparam int CTL_RX_OVF = 2;
   localparam int CTL_RX_AVAIL = 0;

   // ---------------------------------------------------------------
   // Reset values and line timing figures
   // ---------------------------------------------------------------
   localparam logic [DIV_W-1:0] DIV_RST = 13'h0017;
   localparam logic [GAP_W-1:0] GAP_RST = 8'h09;
   localparam logic [LEN_W-1:0] LEN_RST = 10'h000;
   localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
   localparam logic [DIV_W-1:0] DIV_MIN = 13'h0017;  // Lowest supported divisor field
   localparam logic [DIV_W-1:0] DIV_MAX = 13'h1387;  // Highest supported divisor field
   localparam logic [GAP_W-1:0] GAP_BIAS = 8'h07;    // Gap value minus this is idle bits
   localparam logic [GAP_W-1:0] STOP_ONE = 8'h01;
   localparam logic [GAP_W-1:0] STOP_TWO = 8'h02;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // ---------------------------------------------------------------
   // States and carriers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_START = 2'b01,
      TX_DATA = 2'b11,
      TX_STOP = 2'b10
   } fsbt_tx_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b11,
      RX_STOP = 2'b10
   } fsbt_rx_e;

   typedef struct packed {
      logic [DIV_W-1:0] divisor;
      logic [GAP_W-1:0] gap;
      logic use_gap;
      logic one_stop;
   } fsbt_line_cfg_s;

endpackage : fsbt_pkg

// File: fsbt_props.sv
// Port-level checks of the fast serial block transfer port
module fsbt_props #(
   parameter int ADDR_W = 18
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic MEM_REQ,
   input wire logic MEM_WE,
   input wire logic [15:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic SER_TXD
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // Bus answers exactly one cycle after setup
   ready_one_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("ready missing");
   ready_only_a: assert property (PREADY |-> PENABLE && $past(PSEL && !PENABLE))
      else $error("ready out of place");
   err_zero_a: assert property (PSLVERR |-> PREADY && PRDATA == 0) else $error("bad error");
   unmapped_a: assert property (PSEL && !PENABLE && PADDR[ADDR_W-1:2] == 0 |=> PSLVERR)
      else $error("unmapped accepted");
   // Memory request holds until acknowledged, then drops
   mem_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
      && $stable(MEM_WE)) else $error("request moved");
   mem_drop_a: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ) else $error("no drop");
   reset_idle_a: assert property ($rose(ARST_N) |-> SER_TXD && !MEM_REQ)
      else $error("not idle after reset");
   // Start bit lasts the full bit time of the reset divisor
   start_bit_a: assert property ($fell(SER_TXD) |-> !SER_TXD [*8] ##16 !SER_TXD)
      else $error("short start bit");
endmodule : fsbt_props
bind fsbt_top fsbt_props #(.ADDR_W(ADDR_W)) u_props (.CLK(CLK), .ARST_N(ARST_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
   .MEM_ACK(MEM_ACK), .SER_TXD(SER_TXD));

// File: fsbt_serial.sv
// Bit-level transmitter and receiver of the fast serial port
module fsbt_serial (
   input wire logic clk,                             // Block clock
   input wire logic arst_n,                          // Async reset, active low
   input fsbt_pkg::fsbt_line_cfg_s cfg,              // Divisor, gap and stop selection
   input wire logic tx_go,                           // Start one byte, one-cycle pulse
   input wire logic [fsbt_pkg::BYTE_W-1:0] tx_byte,  // Byte to send
   output logic tx_idle,                             // Transmitter free
   output logic txd,                                 // Serial out, idle high
   input wire logic rxd,                             // Serial in, unsynchronised
   output logic rx_strobe,                           // Byte received, one-cycle pulse
   output logic [fsbt_pkg::BYTE_W-1:0] rx_byte       // Received byte
);
   import fsbt_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      fsbt_tx_e tx_st;
      logic [DIV_W-1:0] tx_cnt;
      logic [2:0] tx_bit;
      logic [GAP_W-1:0] tx_stop;
      logic [BYTE_W-1:0] tx_sh;
      logic txd;
      logic tx_idle;
      logic rxd_meta;
      logic rxd_sync;
      fsbt_rx_e rx_st;
      logic [DIV_W-1:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [BYTE_W-1:0] rx_sh;
      logic rx_strobe;
      logic [BYTE_W-1:0] rx_byte;
   } fsbt_ser_s;

   localparam fsbt_ser_s SER_RST = '{txd: 1'b1, tx_idle: 1'b1, rxd_meta: 1'b1,
                                     rxd_sync: 1'b1, tx_st: TX_IDLE, rx_st: RX_IDLE,
                                     default: '0};

   fsbt_ser_s s;
   fsbt_ser_s next_s;

   // Idle bit times after the data bits
   function automatic logic [GAP_W-1:0] stop_len(input fsbt_line_cfg_s c);
      logic [GAP_W-1:0] len;
      len = c.one_stop ? STOP_ONE : STOP_TWO;
      if (c.use_gap) begin
         // At least one stop bit so the next start edge stays visible
         len = (c.gap > GAP_BIAS) ? c.gap - GAP_BIAS : STOP_ONE;
      end
      return len;
   endfunction : stop_len

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.rx_strobe = 1'b0;
      // Transmit: every bit lasts divisor + 1 clocks
      case (s.tx_st)
         TX_IDLE: begin
            next_s.txd = 1'b1;
            if (tx_go) begin
               next_s.tx_sh = tx_byte;
               next_s.tx_cnt = cfg.divisor; // [R01]
               next_s.txd = 1'b0;
               next_s.tx_idle = 1'b0;
               next_s.tx_st = TX_START;
            end
         end
         TX_START: begin
            if (s.tx_cnt == '0) begin
               next_s.tx_cnt = cfg.divisor; // [R01]
               next_s.txd = s.tx_sh[0];
               next_s.tx_sh = s.tx_sh >> 1;
               next_s.tx_bit = '0;
               next_s.tx_st = TX_DATA;
            end else begin
               next_s.tx_cnt = s.tx_cnt - 1'b1;
            end
         end
         TX_DATA: begin
            if (s.tx_cnt == '0) begin
               next_s.tx_cnt = cfg.divisor;
               if (s.tx_bit == LAST_BIT) begin
                  next_s.txd = 1'b1;
                  next_s.tx_stop = stop_len(cfg); // [R03] [R04]
                  next_s.tx_st = TX_STOP;
               end else begin
                  next_s.tx_bit = s.tx_bit + 1'b1;
                  next_s.txd = s.tx_sh[0];
                  next_s.tx_sh = s.tx_sh >> 1;
               end
            end else begin
               next_s.tx_cnt = s.tx_cnt - 1'b1;
            end
         end
         TX_STOP: begin
            if (s.tx_cnt != '0) begin
               next_s.tx_cnt = s.tx_cnt - 1'b1;
            end else if (s.tx_stop <= STOP_ONE) begin
               next_s.tx_idle = 1'b1;
               next_s.tx_st = TX_IDLE;
            end else begin
               next_s.tx_stop = s.tx_stop - 1'b1; // [R04]
               next_s.tx_cnt = cfg.divisor;
            end
         end
         default: begin
            next_s.tx_st = TX_IDLE;
            next_s.tx_idle = 1'b1;
            next_s.txd = 1'b1;
         end
      endcase

      // Receive: two-flop synchroniser, then mid-bit sampling
      next_s.rxd_meta = rxd;
      next_s.rxd_sync = s.rxd_meta;
      case (s.rx_st)
         RX_IDLE: begin
            if (!s.rxd_sync) begin
               next_s.rx_cnt = cfg.divisor >> 1;
               next_s.rx_st = RX_START;
            end
         end
         RX_START: begin
            if (s.rx_cnt != '0) begin
               next_s.rx_cnt = s.rx_cnt - 1'b1;
            end else if (!s.rxd_sync) begin
               next_s.rx_cnt = cfg.divisor; // [R01]
               next_s.rx_bit = '0;
               next_s.rx_st = RX_DATA;
            end else begin
               // Glitch shorter than half a bit: not a start bit
               next_s.rx_st = RX_IDLE;
            end
         end
         RX_DATA: begin
            if (s.rx_cnt != '0) begin
               next_s.rx_cnt = s.rx_cnt - 1'b1;
            end else begin
               next_s.rx_sh = {s.rxd_sync, s.rx_sh[BYTE_W-1:1]};
               next_s.rx_cnt = cfg.divisor;
               next_s.rx_bit = s.rx_bit + 1'b1;
               if (s.rx_bit == LAST_BIT) begin
                  next_s.rx_st = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (s.rx_cnt != '0) begin
               next_s.rx_cnt = s.rx_cnt - 1'b1;
            end else begin
               // Framing errors are dropped; stop length is free on receive
               next_s.rx_st = RX_IDLE;
               if (s.rxd_sync) begin
                  next_s.rx_strobe = 1'b1;
                  next_s.rx_byte = s.rx_sh;
               end
            end
         end
         default: next_s.rx_st = RX_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= SER_RST;
      end else begin
         s <= next_s;
      end
   end

   assign tx_idle = s.tx_idle;
   assign txd = s.txd;
   assign rx_strobe = s.rx_strobe;
   assign rx_byte = s.rx_byte;

endmodule : fsbt_serial

// File: fsbt_top.sv
// Fast serial port with APB registers and block transfer engines
//
// Operation
// R01: Bit time is divisor field plus one reference clocks; the code counts divisor field plus one block clocks (CLK) instead.
// R02: Software keeps the divisor field between 23 and 4999.
// R03: Gap setting replaces stop-bit choice, only during block transmit.
// R04: Idle between block bytes lasts gap value minus seven bit times.
// R05: Gap register resets to 0x0009, two stop bits.
// R06: Data read returns last received byte outside block receive.
// R07: Data write sends exactly one byte from its low eight bits.
// R08: Software checks transmit slot free before writing data.
// R09: Receive base pointer starts the next block receive.
// R10: Transmit base pointer starts the next block transmit.
// R11: Writing receive length (count minus one) starts block receive.
// R12: Receive length counts down per byte; read shows remainder.
// R13: Writing transmit length (count minus one) starts block transmit.
// R14: Transmit length counts down per byte; read shows remainder.
// R15: Ten-bit lengths read 0x03FF after completion until reloaded.
// R16: Software writes zero to reserved bits.
// R17: Transmit done flag sets at block end, cleared by writing one.
// R18: Receive available flag shows a byte is held.
// R19: Transmit slot free flag shows a byte may be written.
// R20: Engines step through consecutive memory bytes from the base.
// R21: Data writes during a block transmit are ignored.
module fsbt_top #(
   parameter int ADDR_W = fsbt_pkg::APB_AW  // APB address width
) (
   input wire logic CLK,                              // Clock, 40 MHz
   input wire logic ARST_N,                           // Async reset, active low
   input wire logic PSEL,                             // APB select
   input wire logic PENABLE,                          // APB enable
   input wire logic PWRITE,                           // APB direction
   input wire logic [ADDR_W-1:0] PADDR,               // APB byte address
   input wire logic [31:0] PWDATA,                    // APB write data
   output logic [31:0] PRDATA,                        // APB read data
   output logic PREADY,                               // APB ready
   output logic PSLVERR,                              // APB error, unmapped address
   output logic MEM_REQ,                              // Memory request
   output logic MEM_WE,                               // Memory write
   output logic [fsbt_pkg::PTR_W-1:0] MEM_ADDR,       // Memory byte address
   output logic [fsbt_pkg::BYTE_W-1:0] MEM_WDATA,     // Memory write byte
   input wire logic [fsbt_pkg::BYTE_W-1:0] MEM_RDATA, // Memory read byte
   input wire logic MEM_ACK,                          // Memory done
   input wire logic SER_RXD,                          // Serial line in
   output logic SER_TXD                               // Serial line out
);
   import fsbt_pkg::*;

   if (ADDR_W < APB_AW) begin : g_addr_check
      $error("ADDR_W too small for the register map");
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [DIV_W-1:0] divisor;
      logic [GAP_W-1:0] gap;
      logic one_stop;
      logic [PTR_W-1:0] rx_ptr;
      logic [PTR_W-1:0] tx_ptr;
      logic [PTR_W-1:0] rx_cur;
      logic [PTR_W-1:0] tx_cur;
      logic [LEN_W-1:0] rx_len;
      logic [LEN_W-1:0] tx_len;
      logic rx_blk;
      logic tx_blk;
      logic tx_drain;
      logic tx_done;
      logic rx_done;
      logic rx_ovf;
      logic [BYTE_W-1:0] rx_hold;
      logic rx_full;
      logic [BYTE_W-1:0] tx_hold;
      logic tx_pend;
      logic tx_go;
      logic rx_wpend;
      logic [BYTE_W-1:0] rx_wdata;
      logic mem_req;
      logic mem_we;
      logic [PTR_W-1:0] mem_addr;
      logic [BYTE_W-1:0] mem_wdata;
   } fsbt_top_s;

   localparam fsbt_top_s TOP_RST = '{divisor: DIV_RST, gap: GAP_RST, rx_ptr: PTR_RST,
                                     tx_ptr: PTR_RST, rx_len: LEN_RST, tx_len: LEN_RST,
                                     default: '0};

   fsbt_top_s s;
   fsbt_top_s next_s;
   fsbt_line_cfg_s line_cfg;
   logic ser_tx_idle;
   logic ser_rx_strobe;
   logic [BYTE_W-1:0] ser_rx_byte;
   logic [15:0] idx;
   logic setup;
   logic access;
   logic wr;
   logic rd;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Count down; zero wraps to all ones, which is the finished value
   function automatic logic [LEN_W-1:0] len_step(input logic [LEN_W-1:0] len);
      return len - 1'b1;
   endfunction : len_step

   function automatic logic reg_hit(input logic [15:0] i);
      case (i)
         IDX_CTRL, IDX_DIV, IDX_GAP, IDX_DATA, IDX_RX_PTR, IDX_RX_LEN, IDX_TX_PTR,
         IDX_TX_LEN: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : reg_hit

   function automatic logic [31:0] rd_value(input fsbt_top_s t, input logic [15:0] i);
      logic [31:0] v;
      v = '0;
      case (i)
         IDX_CTRL: begin
            v[CTL_RX_BUSY] = t.rx_blk;
            v[CTL_TX_BUSY] = t.tx_blk;
            v[CTL_TX_DONE] = t.tx_done;
            v[CTL_RX_DONE] = t.rx_done;
            v[CTL_ONE_STOP] = t.one_stop;
            v[CTL_TX_FREE] = !t.tx_pend;  // [R19]
            v[CTL_RX_OVF] = t.rx_ovf;
            v[CTL_RX_AVAIL] = t.rx_full;  // [R18]
         end
         IDX_DIV: v = 32'(t.divisor);
         IDX_GAP: v = 32'(t.gap);
         IDX_DATA: v = 32'(t.rx_hold);     // [R06]
         IDX_RX_PTR: v = 32'(t.rx_ptr);
         IDX_RX_LEN: v = 32'(t.rx_len);    // [R12] [R15]
         IDX_TX_PTR: v = 32'(t.tx_ptr);
         IDX_TX_LEN: v = 32'(t.tx_len);    // [R14] [R15]
         default: v = '0;
      endcase
      return v;
   endfunction : rd_value

   // ---------------------------------------------------------------
   // APB decode: no wait states, the access phase always ends at once
   // ---------------------------------------------------------------
   assign idx = PADDR[17:2];
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE && s.pready;
   assign wr = access && PWRITE && !s.pslverr;
   assign rd = access && !PWRITE && !s.pslverr;

   // Gap only counts while a block transmit runs
   assign line_cfg = '{divisor: s.divisor, gap: s.gap, use_gap: s.tx_blk,
                       one_stop: s.one_stop};

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.tx_go = 1'b0;
      next_s.pready = setup;
      next_s.pslverr = setup && !(reg_hit(idx) && PADDR[1:0] == 2'b00);
      if (setup) begin
         next_s.prdata = next_s.pslverr ? '0 : rd_value(s, idx);
      end

      // Clears come first so that a hardware set in the same cycle wins
      if (wr && idx == IDX_CTRL) begin
         if (PWDATA[CTL_TX_DONE]) next_s.tx_done = 1'b0;
         if (PWDATA[CTL_RX_DONE]) next_s.rx_done = 1'b0;
         if (PWDATA[CTL_RX_OVF]) next_s.rx_ovf = 1'b0;
      end
      if (rd && idx == IDX_DATA) begin
         next_s.rx_full = 1'b0;
      end

      // Hand a held byte to the transmitter
      if (s.tx_pend && ser_tx_idle && !s.tx_go) begin
         next_s.tx_go = 1'b1;
         next_s.tx_pend = 1'b0;
         if (s.tx_blk) begin
            next_s.tx_len = len_step(s.tx_len); // [R14] [R15]
            if (s.tx_len == '0) begin
               next_s.tx_drain = 1'b1;
            end
         end
      end
      // Block transmit ends once the last byte has left the line
      if (s.tx_drain && ser_tx_idle && !s.tx_go) begin
         next_s.tx_drain = 1'b0;
         next_s.tx_blk = 1'b0;
         next_s.tx_done = 1'b1; // [R17]
      end

      // Memory port: receive writes go before transmit fetches
      if (s.mem_req) begin
         if (MEM_ACK) begin
            next_s.mem_req = 1'b0;
            if (s.mem_we) begin
               next_s.rx_wpend = 1'b0;
            end else begin
               next_s.tx_hold = MEM_RDATA;
               next_s.tx_pend = 1'b1;
            end
         end
      end else if (s.rx_wpend) begin
         next_s.mem_req = 1'b1;
         next_s.mem_we = 1'b1;
         next_s.mem_addr = s.rx_cur;
         next_s.mem_wdata = s.rx_wdata;
         next_s.rx_cur = s.rx_cur + 1'b1; // [R20]
      end else if (s.tx_blk && !s.tx_drain && !s.tx_pend) begin
         next_s.mem_req = 1'b1;
         next_s.mem_we = 1'b0;
         next_s.mem_addr = s.tx_cur;
         next_s.tx_cur = s.tx_cur + 1'b1; // [R20]
      end

      // Received bytes go to memory in block mode, else to the data register
      if (ser_rx_strobe) begin
         if (s.rx_blk) begin
            if (s.rx_wpend) begin
               next_s.rx_ovf = 1'b1;
            end
            next_s.rx_wpend = 1'b1;
            next_s.rx_wdata = ser_rx_byte;
            next_s.rx_len = len_step(s.rx_len); // [R12] [R15]
            if (s.rx_len == '0) begin
               next_s.rx_blk = 1'b0;
               next_s.rx_done = 1'b1;
            end
         end else begin
            if (s.rx_full && !(rd && idx == IDX_DATA)) begin
               next_s.rx_ovf = 1'b1;
            end
            next_s.rx_hold = ser_rx_byte; // [R06]
            next_s.rx_full = 1'b1;        // [R18]
         end
      end

      // Register writes; a length write also restarts its engine
      if (wr) begin
         case (idx)
            IDX_CTRL: next_s.one_stop = PWDATA[CTL_ONE_STOP];
            IDX_DIV: next_s.divisor = PWDATA[DIV_W-1:0];  // [R01]
            IDX_GAP: next_s.gap = PWDATA[GAP_W-1:0];      // [R04]
            IDX_DATA: begin
               // A block transmit owns the holding register
               if (!s.tx_blk) begin // [R21]
                  next_s.tx_hold = PWDATA[BYTE_W-1:0]; // [R07]
                  next_s.tx_pend = 1'b1;               // [R07]
               end
            end
            IDX_RX_PTR: next_s.rx_ptr = PWDATA[PTR_W-1:0];
            IDX_RX_LEN: begin
               next_s.rx_len = PWDATA[LEN_W-1:0]; // [R11]
               next_s.rx_blk = 1'b1;               // [R11]
               next_s.rx_cur = s.rx_ptr;           // [R09]
            end
            IDX_TX_PTR: next_s.tx_ptr = PWDATA[PTR_W-1:0];
            IDX_TX_LEN: begin
               next_s.tx_len = PWDATA[LEN_W-1:0]; // [R13]
               next_s.tx_blk = 1'b1;               // [R13]
               next_s.tx_drain = 1'b0;
               next_s.tx_cur = s.tx_ptr;           // [R10]
            end
            default: next_s.pslverr = s.pslverr;
         endcase
      end
   end

   // State register
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s <= TOP_RST; // [R05]
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Line engine
   // ---------------------------------------------------------------
   fsbt_serial u_serial (
      .clk(CLK),
      .arst_n(ARST_N),
      .cfg(line_cfg),
      .tx_go(s.tx_go),
      .tx_byte(s.tx_hold),
      .tx_idle(ser_tx_idle),
      .txd(SER_TXD),
      .rxd(SER_RXD),
      .rx_strobe(ser_rx_strobe),
      .rx_byte(ser_rx_byte)
   );

   // Outputs straight from the state register
   assign PRDATA = s.prdata;
   assign PREADY = s.pready;
   assign PSLVERR = s.pslverr;
   assign MEM_REQ = s.mem_req;
   assign MEM_WE = s.mem_we;
   assign MEM_ADDR = s.mem_addr;
   assign MEM_WDATA = s.mem_wdata;

endmodule : fsbt_top

// File: fsbt_top_tb.sv
// Self-checking bench of the fast serial block transfer port
module fsbt_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fsbt_pkg::*;
   logic CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, MEM_ACK = 0;
   logic [17:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, r;
   logic PREADY, PSLVERR, MEM_REQ, MEM_WE, SER_RXD, SER_TXD, e;
   logic [15:0] MEM_ADDR, base, t, wa[$];
   logic [7:0] MEM_WDATA, MEM_RDATA = 0, b, g, x, q[$], wd[$];
   int errors = 0, n_tests = 0;
   always #12.5 CLK = ~CLK;
   fsbt_top uut (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
      .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .SER_RXD(SER_RXD), .SER_TXD(SER_TXD));
   fsbt_peer #(.BT(int'(DIV_RST) + 1)) peer (.clk(CLK), .txd(SER_TXD), .rxd(SER_RXD));
   // Memory answers one cycle late; its content is the inverted low address byte
   always @(posedge CLK) begin
      MEM_ACK <= MEM_REQ && !MEM_ACK;
      MEM_RDATA <= ~MEM_ADDR[7:0];
      if (MEM_REQ && MEM_ACK && MEM_WE) begin
         wa.push_back(MEM_ADDR);
         wd.push_back(MEM_WDATA);
      end
   end
   task automatic chk(input logic [31:0] v, input logic [31:0] w);
      n_tests++;
      if (v !== w) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, v, w);
      end
   endtask : chk
   task automatic final_report;
      if (errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   // One APB transfer; the request holds until ready is seen
   task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {i, 2'h0};
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // Ready, read data and error are all taken at the edge that sees ready high
      do begin
         @(posedge CLK);
         k++;
      end while (PREADY !== 1'b1 && k < 40);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1) begin
         errors++;
         final_report();
      end
   endtask : apb
   initial begin
      void'($urandom(32'h6926));
      repeat (6) @(posedge CLK);
      ARST_N <= 1'b1;
      apb(0, IDX_GAP, 0); chk(r, 32'h9);
      apb(0, IDX_TX_LEN, 0); chk(r, 0);
      apb(0, 16'h0, 0); chk({31'h0, e}, 1);
      base = $urandom;
      apb(1, IDX_TX_PTR, {16'h0, base}); apb(0, IDX_TX_PTR, 0); chk(r, {16'h0, base});
      b = $urandom;
      apb(0, IDX_CTRL, 0); chk(r[CTL_TX_FREE], 1);
      apb(1, IDX_DATA, {24'h0, b}); peer.get(g); chk(g, b);
      b = $urandom;
      peer.send(b); apb(0, IDX_CTRL, 0); chk(r[0], 1);
      apb(0, IDX_DATA, 0); chk(r, b);
      apb(0, IDX_CTRL, 0); chk(r[0], 0);
      // Block transmit of three bytes from consecutive memory
      apb(1, IDX_TX_LEN, 2);
      for (int i = 0; i < 3; i++) begin
         t = base + 16'(i);
         x = ~t[7:0];
         peer.get(g); chk(g, x);
      end
      r = 0;
      for (int k = 0; k < 30 && r[CTL_TX_DONE] !== 1'b1; k++) apb(0, IDX_CTRL, 0);
      chk(r[CTL_TX_DONE], 1);
      apb(0, IDX_TX_LEN, 0); chk(r, 32'h3FF);
      apb(1, IDX_CTRL, 32'h80); apb(0, IDX_CTRL, 0); chk(r[CTL_TX_DONE], 0);
      // Block receive of two bytes into consecutive memory
      apb(1, IDX_RX_PTR, {16'h0, base}); apb(1, IDX_RX_LEN, 1);
      for (int i = 0; i < 2; i++) begin
         b = $urandom;
         q.push_back(b);
         peer.send(b);
         apb(0, IDX_RX_LEN, 0); chk(r, i ? 32'h3FF : 32'h0);
      end
      chk(wa.size(), 2);
      for (int i = 0; i < 2 && i < wa.size(); i++) begin
         chk(wa[i], base + 16'(i));
         chk(wd[i], q[i]);
      end
      final_report();
   end
endmodule : fsbt_top_tb
